// file: cij_map.svh
// Purpose: constants of the compare, immediate and jump unit
// Assumes: included by the package by bare name; modules rely on its macros
// Notes:   definitions only
`ifndef CIJ_MAP_SVH
`define CIJ_MAP_SVH

`define CIJ_DATA_W         32
`define CIJ_IMM7_W         7
`define CIJ_INDEX_W        7
`define CIJ_GUARD_BIT      0
`define CIJ_COND_BIT       0
`define CIJ_OP_CODE_W      3
`define CIJ_OP_COUNT       3'h5
`define CIJ_RESULT_TRUE    32'h0000_0001
`define CIJ_RESULT_FALSE   32'h0000_0000
`define CIJ_WR_DATA_RESET  32'h0000_0000
`define CIJ_PC_RESET       32'h0000_0000
`define CIJ_DPC_RESET      32'h0000_0000
`define CIJ_SPC_RESET      32'h0000_0000

`endif

// file: cij_pkg.sv
// Purpose: shared types of the compare, immediate and jump unit
// Assumes: cij_map.svh supplies widths
// Notes:   operation codes are the order of the enum
`include "cij_map.svh"

package cij_pkg;

   typedef enum logic [`CIJ_OP_CODE_W-1:0]
   {
      CIJ_OP_CMP_GT_REG,
      CIJ_OP_CMP_GT_IMM,
      CIJ_OP_LOAD_IMM,
      CIJ_OP_JUMP_FALSE,
      CIJ_OP_JUMP_IMM
   } cij_op_type;

   typedef enum logic [1:0]
   {
      CIJ_SVC_NONE,
      CIJ_SVC_EXCEPTION,
      CIJ_SVC_INTERRUPT
   } cij_svc_type;

endpackage : cij_pkg

// file: cij_signed_greater.sv
// Purpose: signed greater-than comparator
// Assumes: both operands are two's complement of equal width
// Notes:   purely combinational, registered by the caller
`timescale 1ns/1ps

module cij_signed_greater
   import cij_pkg::*;
#(
   parameter int WIDTH = `CIJ_DATA_W
)
(
   input  wire logic [WIDTH-1:0] first_in,
   input  wire logic [WIDTH-1:0] second_in,
   output logic                  greater_out
);

   always_comb
   begin
      greater_out = ($signed(first_in) > $signed(second_in));
   end

endmodule : cij_signed_greater

// file: cij_exec_unit.sv
// Purpose: executes signed greater compares, immediate load and
//          interruptible jumps with guard and pending-event handling
// Assumes: one operation per cycle at most; the register file and the
//          fetch unit sit outside and follow the write and redirect ports
// Notes:   every result appears one clock after the operation is issued
`timescale 1ns/1ps

module cij_exec_unit
   import cij_pkg::*;
#(
   parameter int DATA_W  = `CIJ_DATA_W,
   parameter int IMM_W   = `CIJ_IMM7_W,
   parameter int INDEX_W = `CIJ_INDEX_W
)
(
   input  wire logic                     clock_in,
   input  wire logic                     rst_n_in,
   input  wire logic                     op_valid_in,
   input  wire logic [`CIJ_OP_CODE_W-1:0] op_code_in,
   input  wire logic                     guard_present_in,
   input  wire logic [DATA_W-1:0]        guard_in,
   input  wire logic [DATA_W-1:0]        first_source_register_in,
   input  wire logic [DATA_W-1:0]        second_source_register_in,
   input  wire logic [DATA_W-1:0]        modifier_in,
   input  wire logic [INDEX_W-1:0]       dest_index_in,
   input  wire logic                     exception_pending_in,
   input  wire logic                     interrupt_pending_in,
   output logic                          wr_en_out,
   output logic [INDEX_W-1:0]            wr_index_out,
   output logic [DATA_W-1:0]             wr_data_out,
   output logic [DATA_W-1:0]             destination_program_counter_out,
   output logic [DATA_W-1:0]             program_counter_out,
   output logic [DATA_W-1:0]             start_program_counter_out,
   output logic                          redirect_out,
   output logic                          service_exception_out,
   output logic                          service_interrupt_out,
   output logic                          jump_cancel_out,
   output logic                          illegal_op_out,
   output logic                          retire_out
);

   // guard test is shared by every guarded operation, the condition test by the jump on false only
   function automatic logic guard_passes
   (
      input logic            present,
      input logic [DATA_W-1:0] value
   );
      guard_passes = !present || value[`CIJ_GUARD_BIT];
   endfunction : guard_passes

   function automatic logic [DATA_W-1:0] sign_extend_imm
   (
      input logic [DATA_W-1:0] modifier
   );
      logic [IMM_W-1:0] short_imm;
      short_imm       = modifier[IMM_W-1:0];
      sign_extend_imm = {{(DATA_W-IMM_W){short_imm[IMM_W-1]}}, short_imm};
   endfunction : sign_extend_imm

   function automatic logic [DATA_W-1:0] bool_word
   (
      input logic flag
   );
      bool_word = flag ? DATA_W'(`CIJ_RESULT_TRUE)
                       : DATA_W'(`CIJ_RESULT_FALSE);
   endfunction : bool_word

   // decode
   logic                op_legal;
   cij_op_type          op;
   logic                guard_ok;
   logic [DATA_W-1:0]   imm_operand;
   logic                gt_reg;
   logic                gt_imm;
   logic                cond_false;
   cij_svc_type         svc_choice;

   // write-back group
   logic                wr_en_reg;
   logic                wr_en_next;
   logic [INDEX_W-1:0]  wr_index_reg;
   logic [INDEX_W-1:0]  wr_index_next;
   logic [DATA_W-1:0]   wr_data_reg;
   logic [DATA_W-1:0]   wr_data_next;

   // flow group
   logic [DATA_W-1:0]   dpc_reg;
   logic [DATA_W-1:0]   dpc_next;
   logic [DATA_W-1:0]   pc_reg;
   logic [DATA_W-1:0]   pc_next;
   logic [DATA_W-1:0]   spc_reg;
   logic [DATA_W-1:0]   spc_next;
   logic                redirect_reg;
   logic                redirect_next;
   logic                svc_exc_reg;
   logic                svc_exc_next;
   logic                svc_int_reg;
   logic                svc_int_next;
   logic                cancel_reg;
   logic                cancel_next;

   // status group
   logic                illegal_reg;
   logic                illegal_next;
   logic                retire_reg;
   logic                retire_next;

   cij_signed_greater
   #(
      .WIDTH       (DATA_W)
   )
   u_gt_reg
   (
      .first_in    (first_source_register_in),
      .second_in   (second_source_register_in),
      .greater_out (gt_reg)
   );

   cij_signed_greater
   #(
      .WIDTH       (DATA_W)
   )
   u_gt_imm
   (
      .first_in    (first_source_register_in),
      .second_in   (imm_operand),
      .greater_out (gt_imm)
   );

   always_comb
   begin
      op_legal    = (op_code_in < `CIJ_OP_COUNT);
      op          = cij_op_type'(op_code_in);
      guard_ok    = guard_passes(guard_present_in, guard_in);
      imm_operand = sign_extend_imm(modifier_in);
      cond_false  = !first_source_register_in[`CIJ_COND_BIT];
      // pending lines are looked at in the issue cycle, the same edge
      // that commits the counters, so choice and update cannot disagree
      if (exception_pending_in)
      begin
         svc_choice = CIJ_SVC_EXCEPTION;
      end
      else if (interrupt_pending_in)
      begin
         svc_choice = CIJ_SVC_INTERRUPT;
      end
      else
      begin
         svc_choice = CIJ_SVC_NONE;
      end
   end

   // write-back: destination untouched simply means no write strobe
   always_comb
   begin
      wr_en_next    = 1'b0;
      wr_index_next = wr_index_reg;
      wr_data_next  = wr_data_reg;
      if (op_valid_in && op_legal)
      begin
         unique case (op)
            CIJ_OP_CMP_GT_REG:
            begin
               if (guard_ok)
               begin
                  wr_en_next    = 1'b1;
                  wr_index_next = dest_index_in;
                  wr_data_next  = bool_word(gt_reg);
               end
            end
            CIJ_OP_CMP_GT_IMM:
            begin
               if (guard_ok)
               begin
                  wr_en_next    = 1'b1;
                  wr_index_next = dest_index_in;
                  wr_data_next  = bool_word(gt_imm);
               end
            end
            CIJ_OP_LOAD_IMM:
            begin
               // the guard port is ignored here on purpose
               wr_en_next    = 1'b1;
               wr_index_next = dest_index_in;
               wr_data_next  = modifier_in;
            end
            CIJ_OP_JUMP_FALSE,
            CIJ_OP_JUMP_IMM:
            begin
               wr_en_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wr_en_reg    <= 1'b0;
         wr_index_reg <= '0;
         wr_data_reg  <= DATA_W'(`CIJ_WR_DATA_RESET);
      end
      else
      begin
         wr_en_reg    <= wr_en_next;
         wr_index_reg <= wr_index_next;
         wr_data_reg  <= wr_data_next;
      end
   end

   // flow: both jump forms share one take/service path
   always_comb
   begin
      logic              take;
      logic [DATA_W-1:0] target;
      take          = 1'b0;
      target        = second_source_register_in;
      dpc_next      = dpc_reg;
      pc_next       = pc_reg;
      spc_next      = spc_reg;
      redirect_next = 1'b0;
      svc_exc_next  = 1'b0;
      svc_int_next  = 1'b0;
      cancel_next   = 1'b0;
      if (op_valid_in && op_legal)
      begin
         unique case (op)
            CIJ_OP_JUMP_FALSE:
            begin
               target = second_source_register_in;
               if (!guard_ok)
               begin
                  cancel_next = 1'b1;
               end
               else
               begin
                  // a set condition bit falls through untouched
                  take = cond_false;
               end
            end
            CIJ_OP_JUMP_IMM:
            begin
               target = modifier_in;
               if (!guard_ok)
               begin
                  cancel_next = 1'b1;
               end
               else
               begin
                  take = 1'b1;
               end
            end
            CIJ_OP_CMP_GT_REG,
            CIJ_OP_CMP_GT_IMM,
            CIJ_OP_LOAD_IMM:
            begin
               take = 1'b0;
            end
         endcase
      end
      if (take)
      begin
         dpc_next = target;
         unique case (svc_choice)
            CIJ_SVC_EXCEPTION:
            begin
               svc_exc_next = 1'b1;
            end
            CIJ_SVC_INTERRUPT:
            begin
               svc_int_next = 1'b1;
            end
            CIJ_SVC_NONE:
            begin
               pc_next       = target;
               spc_next      = target;
               redirect_next = 1'b1;
            end
            default:
            begin
               svc_exc_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         dpc_reg      <= DATA_W'(`CIJ_DPC_RESET);
         pc_reg       <= DATA_W'(`CIJ_PC_RESET);
         spc_reg      <= DATA_W'(`CIJ_SPC_RESET);
         redirect_reg <= 1'b0;
         svc_exc_reg  <= 1'b0;
         svc_int_reg  <= 1'b0;
         cancel_reg   <= 1'b0;
      end
      else
      begin
         dpc_reg      <= dpc_next;
         pc_reg       <= pc_next;
         spc_reg      <= spc_next;
         redirect_reg <= redirect_next;
         svc_exc_reg  <= svc_exc_next;
         svc_int_reg  <= svc_int_next;
         cancel_reg   <= cancel_next;
      end
   end

   // status: unknown codes do nothing but are reported
   always_comb
   begin
      illegal_next = op_valid_in && !op_legal;
      retire_next  = op_valid_in && op_legal;
   end

   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         illegal_reg <= 1'b0;
         retire_reg  <= 1'b0;
      end
      else
      begin
         illegal_reg <= illegal_next;
         retire_reg  <= retire_next;
      end
   end

   always_comb
   begin
      wr_en_out                       = wr_en_reg;
      wr_index_out                    = wr_index_reg;
      wr_data_out                     = wr_data_reg;
      destination_program_counter_out = dpc_reg;
      program_counter_out             = pc_reg;
      start_program_counter_out       = spc_reg;
      redirect_out                    = redirect_reg;
      service_exception_out           = svc_exc_reg;
      service_interrupt_out           = svc_int_reg;
      jump_cancel_out                 = cancel_reg;
      illegal_op_out                  = illegal_reg;
      retire_out                      = retire_reg;
   end

endmodule : cij_exec_unit

// file: cij_exec_unit_chk.sv
// Purpose: port-level assertions for the compare, immediate and jump unit
// Assumes: one clock, results one cycle after issue
// Notes:   helper wires hold the issue-cycle conditions
`timescale 1ns/1ps

module cij_exec_unit_chk
(
   input wire logic        clock_in,
   input wire logic        rst_n_in,
   input wire logic        op_valid_in,
   input wire logic [2:0]  op_code_in,
   input wire logic        guard_present_in,
   input wire logic [31:0] guard_in,
   input wire logic [31:0] first_source_register_in,
   input wire logic [31:0] second_source_register_in,
   input wire logic [31:0] modifier_in,
   input wire logic        exception_pending_in,
   input wire logic        interrupt_pending_in,
   input wire logic        wr_en_out,
   input wire logic [31:0] wr_data_out,
   input wire logic [31:0] destination_program_counter_out,
   input wire logic [31:0] program_counter_out,
   input wire logic [31:0] start_program_counter_out,
   input wire logic        redirect_out,
   input wire logic        service_exception_out,
   input wire logic        service_interrupt_out,
   input wire logic        jump_cancel_out,
   input wire logic        illegal_op_out,
   input wire logic        retire_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   wire        ok     = !guard_present_in || guard_in[0];
   wire        go     = op_valid_in && ok;
   wire [31:0] imm7   = {{25{modifier_in[6]}}, modifier_in[6:0]};
   wire        gt_reg = $signed(first_source_register_in) >
                        $signed(second_source_register_in);
   wire        gt_imm = $signed(first_source_register_in) > $signed(imm7);
   wire        jf     = go && op_code_in == 3'h3 &&
                        !first_source_register_in[0];
   wire        ji     = go && op_code_in == 3'h4;
   wire        pend   = exception_pending_in || interrupt_pending_in;
   wire [31:0] tgt    = (op_code_in == 3'h3) ? second_source_register_in
                                             : modifier_in;

   a_cmp_reg_value: assert property (go && op_code_in == 3'h0 |=> wr_en_out && wr_data_out == {31'h0, $past(gt_reg)}) else $error("register compare result wrong");
   a_guard_no_write: assert property (op_valid_in && op_code_in < 3'h2 && !ok |=> !wr_en_out && retire_out) else $error("false guard still wrote");
   a_cmp_imm_value: assert property (go && op_code_in == 3'h1 |=> wr_en_out && wr_data_out == {31'h0, $past(gt_imm)}) else $error("immediate compare result wrong");
   a_load_always: assert property (op_valid_in && op_code_in == 3'h2 |=> wr_en_out && wr_data_out == $past(modifier_in)) else $error("immediate load wrong");
   a_jump_redirect: assert property ((jf || ji) && !pend |=> redirect_out && program_counter_out == $past(tgt) && start_program_counter_out == $past(tgt) && destination_program_counter_out == $past(tgt)) else $error("jump did not load counters");
   a_jump_service: assert property ((jf || ji) && pend |=> destination_program_counter_out == $past(tgt) && !redirect_out && $stable(program_counter_out) && service_exception_out == $past(exception_pending_in) && service_interrupt_out != $past(exception_pending_in)) else $error("pending jump service wrong");
   a_cond_true_stay: assert property (go && op_code_in == 3'h3 && first_source_register_in[0] |=> retire_out && !redirect_out && !jump_cancel_out && $stable(destination_program_counter_out)) else $error("jump taken on true condition");
   a_guard_cancel: assert property (op_valid_in && op_code_in inside {3'h3, 3'h4} && !ok |=> jump_cancel_out && $stable(destination_program_counter_out) && $stable(program_counter_out) && $stable(start_program_counter_out)) else $error("false guard did not cancel jump");
   a_illegal_flag: assert property (op_valid_in && op_code_in > 3'h4 |=> illegal_op_out && !retire_out && !wr_en_out) else $error("illegal code not flagged");
   a_idle_quiet: assert property (!op_valid_in |=> !retire_out && !wr_en_out && !redirect_out) else $error("activity without an operation");

   c_false_exc: cover property (jf && exception_pending_in);
   c_imm_jump: cover property (ji && !pend);
   c_illegal: cover property (op_valid_in && op_code_in > 3'h4);
endmodule : cij_exec_unit_chk

bind cij_exec_unit cij_exec_unit_chk u_cij_exec_unit_chk (.clock_in,
   .rst_n_in, .op_valid_in, .op_code_in, .guard_present_in, .guard_in,
   .first_source_register_in, .second_source_register_in, .modifier_in,
   .exception_pending_in, .interrupt_pending_in, .wr_en_out, .wr_data_out,
   .destination_program_counter_out, .program_counter_out,
   .start_program_counter_out, .redirect_out, .service_exception_out,
   .service_interrupt_out, .jump_cancel_out, .illegal_op_out, .retire_out);

// file: tb_cij_exec_unit.sv
// Purpose: self-checking bench for the compare, immediate and jump unit
// Assumes: one cycle latency, retire or illegal pulse for every issued op
// Notes:   driver queues expected notes, monitor pops them on results
`timescale 1ns/1ps

module tb_cij_exec_unit;
   import cij_pkg::*;
   typedef struct {logic wr; logic [6:0] idx; logic [31:0] data, destination_program_counter, pc,
                   start_program_counter; logic redir, sx, si, canc, ill;} cij_note_type;
   logic        clock_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        op_valid_in = 1'b0;
   logic [2:0]  op_code_in = 3'h0;
   logic        guard_present_in = 1'b0;
   logic        exception_pending_in = 1'b0;
   logic        interrupt_pending_in = 1'b0;
   logic [31:0] guard_in = 32'h0, src1 = 32'h0, src2 = 32'h0, mod = 32'h0;
   logic [6:0]  dest_index_in = 7'h0;
   logic        wr_en_out, redir, sx, si, canc, ill, retire_out;
   logic [6:0]  wr_index_out;
   logic [31:0] wr_data_out, destination_program_counter, pc, start_program_counter;
   logic [31:0] e_data = 32'h0, e_dpc = 32'h0, e_pc = 32'h0, e_spc = 32'h0;
   cij_note_type q[$];
   cij_note_type n;
   int          fails = 0;
   int          samples_checked = 0;
   int          seed = 4317;

   always #50 clock_in = ~clock_in;

   cij_exec_unit u_cij_exec_unit (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .op_valid_in(op_valid_in), .op_code_in(op_code_in),
      .guard_present_in(guard_present_in), .guard_in(guard_in),
      .first_source_register_in(src1), .second_source_register_in(src2),
      .modifier_in(mod), .dest_index_in(dest_index_in),
      .exception_pending_in(exception_pending_in),
      .interrupt_pending_in(interrupt_pending_in), .wr_en_out(wr_en_out),
      .wr_index_out(wr_index_out), .wr_data_out(wr_data_out),
      .destination_program_counter_out(destination_program_counter), .program_counter_out(pc),
      .start_program_counter_out(start_program_counter), .redirect_out(redir),
      .service_exception_out(sx), .service_interrupt_out(si),
      .jump_cancel_out(canc), .illegal_op_out(ill), .retire_out(retire_out));

   task automatic check_bit(input string nm, input logic e, input logic s);
      samples_checked++;
      if (s !== e)
      begin
         fails++;
         $display("mismatch %s expected %b seen %b", nm, e, s);
      end
   endtask : check_bit

   task automatic check_word(input string nm, input logic [31:0] e,
                             input logic [31:0] s);
      samples_checked++;
      if (s !== e)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : check_word

   task automatic print_verdict;
      if (fails == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   // expected effect worked out here, queued before the edge that takes it
   task automatic op(input logic [2:0] c, input logic gp,
                     input logic [31:0] g, a, b, m, input logic ex, it);
      cij_note_type x;
      logic         ok;
      logic [31:0]  t;
      x = '{default: 1'b0, idx: 7'($random(seed)), data: 32'h0, destination_program_counter: 32'h0,
            pc: 32'h0, start_program_counter: 32'h0};
      ok = !gp || g[0];
      x.ill = c > 3'h4;
      t = (c == 3'h3) ? b : m;
      case (c)
         3'h0, 3'h1:
         begin
            x.wr = ok;
            if (ok)
               e_data = {31'h0, $signed(a) > $signed((c == 3'h0) ? b :
                        {{25{m[6]}}, m[6:0]})};
         end
         3'h2:
         begin
            x.wr = 1'b1;
            e_data = m;
         end
         3'h3, 3'h4:
         begin
            x.canc = !ok;
            if (ok && (c == 3'h4 || !a[0]))
            begin
               e_dpc = t;
               x.sx = ex;
               x.si = it && !ex;
               x.redir = !(ex || it);
               if (x.redir)
               begin
                  e_pc = t;
                  e_spc = t;
               end
            end
         end
         default: ;
      endcase
      x.data = e_data;
      x.destination_program_counter = e_dpc;
      x.pc = e_pc;
      x.start_program_counter = e_spc;
      @(posedge clock_in);
      op_valid_in <= 1'b1;
      op_code_in <= c;
      guard_present_in <= gp;
      guard_in <= g;
      src1 <= a;
      src2 <= b;
      mod <= m;
      exception_pending_in <= ex;
      interrupt_pending_in <= it;
      dest_index_in <= x.idx;
      q.push_back(x);
   endtask : op

   always @(negedge clock_in)
   begin
      if (rst_n_in && (retire_out === 1'b1 || ill === 1'b1))
      begin
         if (q.size() == 0)
            check_bit("queue", 1'b1, 1'b0);
         else
         begin
            n = q.pop_front();
            check_bit("wr_en", n.wr, wr_en_out);
            if (n.wr)
            begin
               check_word("wr_data", n.data, wr_data_out);
               check_word("wr_index", {25'h0, n.idx}, {25'h0, wr_index_out});
            end
            check_word("dpc", n.destination_program_counter, destination_program_counter);
            check_word("pc", n.pc, pc);
            check_word("spc", n.start_program_counter, start_program_counter);
            check_bit("redirect", n.redir, redir);
            check_bit("svc_exc", n.sx, sx);
            check_bit("svc_int", n.si, si);
            check_bit("cancel", n.canc, canc);
            check_bit("illegal", n.ill, ill);
            check_bit("retire", !n.ill, retire_out);
         end
      end
   end

   initial
   begin
      repeat (10) @(posedge clock_in);
      rst_n_in <= 1'b1;
      op(3'h0, 0, 0, 3, 4, 0, 0, 0);
      op(3'h0, 1, 0, 32'h100, 3, 0, 0, 0);
      op(3'h0, 1, 1, 32'h1000, 32'h100, 0, 0, 0);
      op(3'h0, 0, 0, 32'h80000000, 4, 0, 0, 0);
      op(3'h0, 0, 0, 32'h8000000, 32'h8000000, 0, 0, 0);
      for (int k = 2; k < 5; k++)
         op(3'h1, 0, 0, 3, 0, k, 0, 0);
      op(3'h1, 1, 0, 32'h100, 0, 32'h3f, 0, 0);
      op(3'h1, 1, 1, 32'h100, 0, 32'h3f, 0, 0);
      op(3'h1, 0, 0, 32'hffffffc1, 0, 32'h12345f40, 0, 0);
      op(3'h1, 0, 0, 32'h40, 0, 32'h3f, 0, 0);
      op(3'h2, 1, 0, 0, 0, 32'h2, 1, 1);
      op(3'h2, 0, 0, 0, 0, 32'hfffc0000, 0, 0);
      op(3'h3, 0, 0, 0, 32'h330, 0, 0, 0);
      op(3'h3, 0, 0, 1, 32'h440, 0, 1, 0);
      op(3'h3, 1, 0, 0, 32'h8000, 0, 0, 0);
      op(3'h3, 1, 1, 0, 32'h8000, 0, 1, 1);
      op(3'h3, 0, 0, 2, 32'h9000, 0, 0, 1);
      op(3'h4, 0, 0, 0, 0, 32'h330, 0, 0);
      op(3'h4, 1, 0, 0, 0, 32'h8000, 1, 0);
      op(3'h4, 1, 1, 0, 0, 32'h8000, 0, 0);
      op(3'h4, 0, 0, 0, 0, 32'h1234, 1, 1);
      op(3'h4, 0, 0, 0, 0, 32'h5678, 0, 1);
      op(3'h4, 0, 0, 0, 0, 32'hffffffff, 0, 0);
      for (int k = 5; k < 8; k++)
         op(3'(k), 0, 0, 0, 0, 0, 0, 0);
      // random mix of codes, guards and pending lines from the seed, issued back to back
      for (int k = 0; k < 60; k++)
         op(3'($random(seed)), 1'($random(seed)), $random(seed),
            $random(seed), $random(seed), $random(seed),
            1'($random(seed)), 1'($random(seed)));
      @(posedge clock_in);
      op_valid_in <= 1'b0;
      for (int k = 0; k < 20 && q.size() != 0; k++)
         @(posedge clock_in);
      if (q.size() != 0)
         fails++;
      print_verdict();
   end
endmodule : tb_cij_exec_unit
